//--- rwu_consts.vh
// Constants of the reset and watchdog unit
`ifndef RWU_CONSTS_VH
`define RWU_CONSTS_VH
`define RWU_ADDR_CLR        8'h93
`define RWU_ADDR_PERIOD     8'h94
`define RWU_ADDR_POWER_REDUCE_CONTROL      8'haf
`define RWU_CLR_KEY         8'h55
`define RWU_CLR_RESET       8'h55
`define RWU_PERIOD_RESET    2'h0
`define RWU_POWER_REDUCE_CONTROL_BO_BIT    0
`define RWU_POWER_REDUCE_CONTROL_WDI_BIT   2
`define RWU_POWER_REDUCE_CONTROL_BO_RESET  1'b1
`define RWU_POWER_REDUCE_CONTROL_WDI_RESET 1'b0
`define RWU_LOW_FILT_LOG2   9
`define RWU_LVR_HOLD_LOG2   16
`define RWU_RING_HOLD       165
`define RWU_EXT_FILT_LOG2   13
`define RWU_EXT_HOLD_LOG2   7
`define RWU_WDT_BASE_LOG2   16
`define RWU_SYS_CLK_HZ      6000000
`define RWU_RING_CLK_HZ     32000
`endif

//--- rwu_top.v
// Reset merger with supply and pin filters, and the watchdog timer
//
// Design decision made here: the strobed register port.
`include "rwu_consts.vh"

// What this block does
// RQ1 - Merge hardware, watchdog, resume, USB resets
// RQ2 - Power-on hold 2^16 clocks plus 165 ring
// RQ3 - Aux brown-out: 2^9 filter, long hold
// RQ4 - Aux brown-out active in every mode
// RQ5 - Core brown-out gated in power-down by bit0
// RQ6 - Bit2 keeps watchdog counting in idle
// RQ7 - Control register spared by watchdog reset
// RQ8 - Core brown-out: 2^9 filter, 2^16 hold
// RQ9 - Regulator brown-out: 2^9 filter, 2^16 hold
// RQ10 - Pin low over 2^13 clocks starts reset
// RQ11 - Pin release adds 2^7 clock hold
// RQ12 - Pin ignored during power-down
// RQ13 - Watchdog overflow raises system reset
// RQ14 - Watchdog cleared and running after reset
// RQ15 - Key 55h at 93h clears watchdog
// RQ16 - Period field selects 2^16 to 2^19
// RQ17 - New period loaded at key clear
// RQ18 - Stops without clock; resume restores defaults
// RQ19 - Watchdog registers reset by all sources
// RQ20 - Runs on the system clock only
// RQ21 - Idle stop holds the count
// RQ22 - Non-key writes leave counter alone
// RQ23 - Sources ORed; stretchers restart on reassert
module rwu_top #(
    parameter LVR_HOLD   = 65536,
    parameter EXT_FILT   = 8192,
    parameter WDT_BASE   = 65536,
    parameter RING_HOLD  = 165,
    parameter RING_DIV   = 188
) (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       por_n,
    input  wire       aux_brownout_detector,
    input  wire       core_brownout_detector,
    input  wire       regulator_brownout_detector,
    input  wire       ext_reset_n,
    input  wire       resume_rst,
    input  wire       usb_rst,
    input  wire       idle_mode,
    input  wire       pd_mode,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_en,
    input  wire       rd_en,
    output reg  [7:0] rdata,
    output reg        sys_rst,
    output reg        hw_rst,
    output reg        wdt_rst
);
    localparam LOW_FILT = 1 << `RWU_LOW_FILT_LOG2;
    localparam EXT_HOLD = 1 << `RWU_EXT_HOLD_LOG2;

    // Two-flop synchronisers for the seven reset and supply pins; idle_mode and pd_mode are used unsynchronised
    reg [6:0] s1_q;
    reg [6:0] s2_q;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
        end
        else
        begin
            s1_q <= {~por_n, aux_brownout_detector, core_brownout_detector,
                     regulator_brownout_detector, ~ext_reset_n, resume_rst, usb_rst};
            s2_q <= s1_q;
        end
    end
    wire por_s  = s2_q[6];
    wire aux_s  = s2_q[5];
    wire core_s = s2_q[4];
    wire reg_s  = s2_q[3];
    wire ext_s  = s2_q[2];
    wire res_s  = s2_q[1];
    wire usb_s  = s2_q[0];

    reg [7:0] ring_div_q;
    wire      ring_tick = (ring_div_q == 8'h00);
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ring_div_q <= 8'h00;
        else if (ring_tick)
            ring_div_q <= RING_DIV[7:0] - 8'h01;
        else
            ring_div_q <= ring_div_q - 8'h01;
    end

    // Control bits read by the core filter and the watchdog below
    reg        prc_bo_q;
    reg        prc_wdi_q;

    // Low-supply filters, one per monitor
    wire [2:0] lo_act;
    wire [2:0] lo_in;
    // RQ5 core gated in power-down
    assign lo_in[0] = aux_s;
    assign lo_in[1] = core_s & ~(pd_mode & ~prc_bo_q);
    assign lo_in[2] = reg_s;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_filt
            // Own flops per monitor, so each bit has one driver
            reg [9:0] cnt_q;
            reg       act_q;
            assign lo_act[gi] = act_q;
            // RQ3 RQ8 RQ9 2^9 filter
            always @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    cnt_q <= 10'h000;
                    act_q <= 1'b0;
                end
                else if (!lo_in[gi])
                begin
                    cnt_q <= 10'h000;
                    act_q <= 1'b0;
                end
                else if (cnt_q >= LOW_FILT[9:0] - 10'h001)
                    act_q <= 1'b1;
                else
                    cnt_q <= cnt_q + 10'h001;
            end
        end
    endgenerate

    // Power-on and aux share one stretcher with ring tail
    reg [16:0] pa_cnt_q;
    reg [7:0]  pa_ring_q;
    reg        pa_rst_q;
    wire       pa_src = por_s | lo_act[0];
    // RQ2 RQ3 RQ4 RQ23 hold and restart
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pa_cnt_q  <= 17'h00000;
            pa_ring_q <= 8'h00;
            pa_rst_q  <= 1'b1;
        end
        else if (pa_src)
        begin
            pa_cnt_q  <= 17'h00000;
            pa_ring_q <= 8'h00;
            pa_rst_q  <= 1'b1;
        end
        else if (pa_rst_q)
        begin
            if (pa_cnt_q < LVR_HOLD[16:0])
                pa_cnt_q <= pa_cnt_q + 17'h00001;
            else if (pa_ring_q < RING_HOLD[7:0])
            begin
                if (ring_tick)
                    pa_ring_q <= pa_ring_q + 8'h01;
            end
            else
                pa_rst_q <= 1'b0;
        end
    end

    // Core and regulator share a plain stretcher
    reg [16:0] lv_cnt_q;
    reg        lv_rst_q;
    // RQ8 RQ9 2^16 hold
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lv_cnt_q <= 17'h00000;
            lv_rst_q <= 1'b0;
        end
        else if (lo_act[1] | lo_act[2])
        begin
            lv_cnt_q <= 17'h00000;
            lv_rst_q <= 1'b1;
        end
        else if (lv_rst_q)
        begin
            if (lv_cnt_q < LVR_HOLD[16:0] - 17'h00001)
                lv_cnt_q <= lv_cnt_q + 17'h00001;
            else
                lv_rst_q <= 1'b0;
        end
    end

    // External pin filter and hold
    reg [13:0] ex_cnt_q;
    reg        ex_act_q;
    reg [7:0]  ex_hold_q;
    reg        ex_rst_q;
    // RQ10 RQ12 width filter, off in power-down
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ex_cnt_q <= 14'h0000;
            ex_act_q <= 1'b0;
        end
        else if (!ext_s || pd_mode)
        begin
            ex_cnt_q <= 14'h0000;
            ex_act_q <= 1'b0;
        end
        else if (ex_cnt_q >= EXT_FILT[13:0])
            ex_act_q <= 1'b1;
        else
            ex_cnt_q <= ex_cnt_q + 14'h0001;
    end
    // RQ11 2^7 hold after release
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ex_hold_q <= 8'h00;
            ex_rst_q  <= 1'b0;
        end
        else if (ex_act_q)
        begin
            ex_hold_q <= 8'h00;
            ex_rst_q  <= 1'b1;
        end
        else if (ex_rst_q)
        begin
            if (ex_hold_q < EXT_HOLD[7:0] - 8'h01)
                ex_hold_q <= ex_hold_q + 8'h01;
            else
                ex_rst_q <= 1'b0;
        end
    end

    // Registers
    reg [1:0]  per_q;
    reg [1:0]  per_act_q;
    reg [19:0] wdt_cnt_q;
    reg        wdt_ovf_q;
    wire       hw_any  = pa_rst_q | lv_rst_q | ex_rst_q;
    wire       soft_rst = hw_any | usb_s | res_s;
    wire       clr_wr  = wr_en && (addr == `RWU_ADDR_CLR);
    // RQ15 RQ22 key only
    wire       key_hit = clr_wr && (wdata == `RWU_CLR_KEY);
    // RQ7 not cleared by watchdog reset
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prc_bo_q  <= `RWU_POWER_REDUCE_CONTROL_BO_RESET;
            prc_wdi_q <= `RWU_POWER_REDUCE_CONTROL_WDI_RESET;
        end
        else if (soft_rst)
        begin
            prc_bo_q  <= `RWU_POWER_REDUCE_CONTROL_BO_RESET;
            prc_wdi_q <= `RWU_POWER_REDUCE_CONTROL_WDI_RESET;
        end
        else if (wr_en && addr == `RWU_ADDR_POWER_REDUCE_CONTROL)
        begin
            prc_bo_q  <= wdata[`RWU_POWER_REDUCE_CONTROL_BO_BIT];
            prc_wdi_q <= wdata[`RWU_POWER_REDUCE_CONTROL_WDI_BIT];
        end
    end

    wire [19:0] wdt_lim = (WDT_BASE[19:0] << per_act_q) - 20'h00001;
    // RQ6 RQ21 idle hold keeps value
    wire        wdt_run = !pd_mode && !(idle_mode && !prc_wdi_q);
    // RQ13 RQ14 RQ16 RQ17 RQ18 RQ19 RQ20 watchdog
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            per_q     <= `RWU_PERIOD_RESET;
            per_act_q <= `RWU_PERIOD_RESET;
            wdt_cnt_q <= 20'h00000;
            wdt_ovf_q <= 1'b0;
        end
        else if (soft_rst || wdt_ovf_q)
        begin
            // Overflow lasts one cycle then restarts from zero
            per_q     <= `RWU_PERIOD_RESET;
            per_act_q <= `RWU_PERIOD_RESET;
            wdt_cnt_q <= 20'h00000;
            wdt_ovf_q <= 1'b0;
        end
        else
        begin
            if (wr_en && addr == `RWU_ADDR_PERIOD)
                per_q <= wdata[1:0];
            if (key_hit)
            begin
                wdt_cnt_q <= 20'h00000;
                per_act_q <= per_q;
            end
            else if (wdt_run)
            begin
                if (wdt_cnt_q >= wdt_lim)
                    wdt_ovf_q <= 1'b1;
                else
                    wdt_cnt_q <= wdt_cnt_q + 20'h00001;
            end
        end
    end

    // Outputs and read port
    // RQ1 RQ23 OR of all sources
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_rst <= 1'b1;
            hw_rst  <= 1'b1;
            wdt_rst <= 1'b0;
            rdata   <= 8'h00;
        end
        else
        begin
            sys_rst <= soft_rst | wdt_ovf_q;
            hw_rst  <= hw_any;
            wdt_rst <= wdt_ovf_q;
            if (rd_en && addr == `RWU_ADDR_PERIOD)
                rdata <= {6'h00, per_q};
            else if (rd_en && addr == `RWU_ADDR_POWER_REDUCE_CONTROL)
                rdata <= {5'h00, prc_wdi_q, 1'b0, prc_bo_q};
            else
                rdata <= 8'h00;
        end
    end
endmodule // rwu_top

//--- rwu_checker_properties.sv
// Port checker of the reset and watchdog unit
module rwu_checker (
    input wire       clk,
    input wire       arst_n,
    input wire       usb_rst,
    input wire       pd_mode,
    input wire       rd_en,
    input wire [7:0] addr,
    input wire [7:0] rdata,
    input wire       sys_rst,
    input wire       hw_rst,
    input wire       wdt_rst
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    reg [2:0] pd_q;
    // Saturates, so a long power-down cannot wrap it
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
            pd_q <= 3'h0;
        else if (!pd_mode)
            pd_q <= 3'h0;
        else if (pd_q != 3'h7)
            pd_q <= pd_q + 3'h1;
    chk_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data outside a read");
    chk_unmapped_zero: assert property (rd_en && addr != 8'h94 && addr != 8'haf |=> rdata == 8'h00)
        else $error("write-only or unmapped read not zero");
    chk_ctrl_reserved: assert property (rd_en && addr == 8'haf |=> rdata[7:3] == 5'h0 && !rdata[1])
        else $error("reserved control bits not zero");
    chk_wdt_pulse_one: assert property (wdt_rst |=> !wdt_rst)
        else $error("watchdog pulse too long");
    chk_wdt_to_sys: assert property (wdt_rst |-> ##[0:2] sys_rst)
        else $error("watchdog overflow without chip reset");
    chk_hw_to_sys: assert property (hw_rst |-> ##[0:1] sys_rst)
        else $error("hardware reset not merged");
    chk_usb_to_sys: assert property (usb_rst [*4] |-> ##[0:2] sys_rst)
        else $error("bus reset not merged");
    chk_pd_no_wdt: assert property (pd_q == 3'h7 |-> !wdt_rst)
        else $error("watchdog overflow in power-down");
    cov_wdt: cover property ($rose(wdt_rst));
    cov_pd_hw: cover property (hw_rst && pd_mode);
    cov_release: cover property ($fell(sys_rst));
endmodule // rwu_checker
bind rwu_top rwu_checker chk_u (.clk, .arst_n, .usb_rst, .pd_mode, .rd_en, .addr, .rdata,
    .sys_rst, .hw_rst, .wdt_rst);

//--- rwu_supply_model.sv
// Model of the supply monitors and the external reset pin
module rwu_supply_model (
    input  wire logic clk,
    output wire logic por_n,
    output wire logic aux_brownout_detector,
    output wire logic core_brownout_detector,
    output wire logic regulator_brownout_detector,
    output wire logic ext_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] low_q = 5'h00;
    assign aux_brownout_detector = low_q[0];
    assign core_brownout_detector = low_q[1];
    assign regulator_brownout_detector = low_q[2];
    // Pin has a pull-up, so released means high
    assign ext_reset_n = ~low_q[3];
    assign por_n = ~low_q[4];
    task automatic drop(input int k, input int len);
        @(posedge clk);
        low_q[k] <= 1'b1;
        repeat (len) @(posedge clk);
        low_q[k] <= 1'b0;
        #1;
    endtask
endmodule // rwu_supply_model

//--- tb.sv
// Self-checking bench of the reset and watchdog unit
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, arst_n, resume_rst, usb_rst, idle_mode, pd_mode, wr_en, rd_en;
    logic [7:0] addr, wdata;
    wire  [7:0] rdata;
    wire        sys_rst, hw_rst, wdt_rst, por_n, ext_reset_n;
    wire        aux_brownout_detector, core_brownout_detector, regulator_brownout_detector;
    wire  [2:0] rs = {wdt_rst, hw_rst, sys_rst};
    int         failures, n_compared, n, p;
    // Short counts keep the supply holds to tens of cycles; the pin hold stays 128
    rwu_top #(.LVR_HOLD(64), .EXT_FILT(32), .WDT_BASE(16), .RING_HOLD(3), .RING_DIV(2)) dut_u (
        .clk, .arst_n, .por_n, .aux_brownout_detector, .core_brownout_detector,
        .regulator_brownout_detector, .ext_reset_n, .resume_rst, .usb_rst, .idle_mode,
        .pd_mode, .addr, .wdata, .wr_en, .rd_en, .rdata, .sys_rst, .hw_rst, .wdt_rst);
    rwu_supply_model sup_u (.clk, .por_n, .aux_brownout_detector, .core_brownout_detector,
        .regulator_brownout_detector, .ext_reset_n);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wt(input int k, input logic v, input int mx);
        n = 0;
        while (rs[k] !== v)
        begin
            @(posedge clk) #1;
            n++;
            if (n > mx)
            begin
                failures++;
                final_report();
            end
        end
    endtask
    task automatic stay(input int k, input logic v, input int c);
        int bad;
        bad = 0;
        repeat (c)
        begin
            @(posedge clk) #1;
            bad += int'(rs[k] !== v);
        end
        chkn(bad, 0, 0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk8(rdata, e);
    endtask
    // Syncs to a fresh watchdog reset so the next count starts at zero
    task automatic fresh;
        wt(2, 1'b1, 600);
        repeat (3) @(posedge clk) #1;
        wt(0, 1'b0, 200);
    endtask
    task automatic final_report;
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {arst_n, resume_rst, usb_rst, idle_mode, pd_mode, wr_en, rd_en} = 7'h0;
        {addr, wdata, failures, n_compared} = '0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        wt(0, 1'b0, 200);
        chkn(n, 68, 80);
        rd(8'haf, 8'h01);
        rd(8'h93, 8'h00);
        rd(8'h10, 8'h00);
        for (p = 0; p < 4; p++)
        begin
            fresh();
            rd(8'h94, 8'h00);
            wr(8'h94, 8'hfc | p[7:0]);
            rd(8'h94, p[7:0]);
            wr(8'h93, 8'h55);
            wt(2, 1'b1, 600);
            chkn(n, (16 << p) - 2, (16 << p) + 2);
        end
        fresh();
        wr(8'h94, 8'h03);
        wr(8'h93, 8'haa);
        wt(2, 1'b1, 40);
        chkn(n, 0, 13);
        fresh();
        repeat (4) @(posedge clk);
        idle_mode <= 1'b1;
        stay(2, 1'b0, 100);
        @(posedge clk) idle_mode <= 1'b0;
        wt(2, 1'b1, 40);
        chkn(n, 0, 13);
        fresh();
        wr(8'haf, 8'hff);
        @(posedge clk) idle_mode <= 1'b1;
        fresh();
        rd(8'haf, 8'h05);
        wr(8'haf, 8'h01);
        sup_u.drop(3, 20);
        stay(0, 1'b0, 40);
        sup_u.drop(3, 60);
        wt(1, 1'b0, 400);
        chkn(n, 126, 134);
        @(posedge clk) pd_mode <= 1'b1;
        sup_u.drop(3, 60);
        stay(0, 1'b0, 40);
        sup_u.drop(1, 600);
        wt(1, 1'b0, 200);
        chkn(n, 62, 70);
        wr(8'haf, 8'h00);
        sup_u.drop(1, 600);
        stay(0, 1'b0, 10);
        sup_u.drop(0, 600);
        wt(1, 1'b0, 200);
        chkn(n, 66, 80);
        @(posedge clk) pd_mode <= 1'b0;
        sup_u.drop(2, 200);
        stay(0, 1'b0, 10);
        sup_u.drop(2, 600);
        wt(1, 1'b0, 200);
        chkn(n, 62, 70);
        sup_u.drop(4, 5);
        wt(1, 1'b0, 200);
        chkn(n, 66, 80);
        for (p = 0; p < 2; p++)
        begin
            wr(8'haf, 8'h04);
            @(posedge clk) {usb_rst, resume_rst} <= (p == 0) ? 2'h2 : 2'h1;
            repeat (5) @(posedge clk);
            {usb_rst, resume_rst} <= 2'h0;
            wt(0, 1'b0, 200);
            rd(8'haf, 8'h01);
        end
        final_report();
    end
endmodule // tb
